// >>> dv/core_model.sv
// Purpose: instruction sequencer strobes of the processor core
// Assumes: strobes change just after the rising edge
// Notes: slow mode spaces strobes like multi-cycle instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  output logic mcycle_o,
  output logic boundary_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 2'h0;
      mcycle_o <= 1'b0;
      boundary_o <= 1'b0;
    end else begin
      cnt_q <= (slow_i && cnt_q != 2'h2) ? cnt_q + 2'h1 : 2'h0;
      mcycle_o <= !slow_i || cnt_q == 2'h2;
      boundary_o <= !slow_i || cnt_q == 2'h2;
    end
  end
endmodule // core_model
`default_nettype wire

// >>> dv/irq_ctl_checker.sv
// Purpose: port-level checker of the interrupt controller
// Assumes: one clock, asynchronous active-high reset
// Notes: global enable mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic instr_boundary_i,
  input wire logic reti_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic irq_call_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic timer_zero_vector_ack_o,
  input wire logic timer_one_vector_ack_o,
  input wire logic [2:0] active_level_o
);
  logic gie_q;
  wire cfg_wr = sfr_wr_i && (sfr_addr_i inside {8'ha8, 8'hb8, 8'h9a, 8'ha9, 8'hb9});
  // mirror only the global bit, the rest is judged by the bench
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gie_q <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == 8'ha8) begin
      gie_q <= sfr_wdata_i[7];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_call_pulse: assert property (irq_call_o |=> !irq_call_o)
    else $error("call held longer than one cycle");
  a_call_boundary: assert property (irq_call_o |-> $past(instr_boundary_i))
    else $error("call without instruction boundary");
  a_global_gate: assert property (irq_call_o |-> $past(gie_q))
    else $error("call while global enable clear");
  a_reti_defer: assert property (reti_i |=> !irq_call_o)
    else $error("call during return");
  a_cfg_defer: assert property (cfg_wr |=> !irq_call_o)
    else $error("call during enable or priority write");
  a_timer0_ack: assert property (timer_zero_vector_ack_o == (irq_call_o && irq_vector_o == 16'h000b))
    else $error("timer zero ack mismatch");
  a_timer1_ack: assert property (timer_one_vector_ack_o == (irq_call_o && irq_vector_o == 16'h001b))
    else $error("timer one ack mismatch");
  a_level_rise: assert property (irq_call_o |-> active_level_o != 3'h4 &&
    ($past(active_level_o) == 3'h4 || active_level_o > $past(active_level_o)))
    else $error("call not above active level");
  a_reti_pop: assert property (reti_i && active_level_o != 3'h4 |=>
    active_level_o == 3'h4 || active_level_o < $past(active_level_o))
    else $error("return did not end level");
  a_vector_map: assert property (irq_call_o |-> irq_vector_o inside {16'h0003, 16'h000b,
    16'h0013, 16'h001b, 16'h0023, 16'h0083, 16'h004b, 16'h0053, 16'h005b, 16'h0063,
    16'h006b})
    else $error("vector outside table");
endmodule // irq_ctl_checker
bind mpu_interrupt_controller irq_ctl_checker irq_ctl_checker_i (.mclk_i(mclk_i),
  .reset_i(reset_i), .instr_boundary_i(instr_boundary_i), .reti_i(reti_i),
  .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o),
  .timer_zero_vector_ack_o(timer_zero_vector_ack_o),
  .timer_one_vector_ack_o(timer_one_vector_ack_o), .active_level_o(active_level_o));
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: core strobes from core_model, software played by tasks
// Notes: serial requests and timer one stay idle
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i, reset_i, slow, sfr_wr_i, sfr_rd_i, xram_wr_i, reti_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, xram_wdata_i;
  logic [15:0] xram_addr_i;
  logic t0, t1, s0, s1, e0, e1, fca, fcb, spi, ce, pll, ee, xf, sec, wdn, btn, twk, wake;
  wire mcycle_i, instr_boundary_i, irq_call_o, ack0, ack1;
  wire [7:0] sfr_rdata_o, xram_rdata_o;
  wire [15:0] irq_vector_o;
  wire [2:0] active_level_o;
  int n_errors, n_compared;
  mpu_interrupt_controller mpu_interrupt_controller_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .mcycle_i(mcycle_i), .instr_boundary_i(instr_boundary_i), .reti_i(reti_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .xram_wr_i(xram_wr_i),
    .xram_addr_i(xram_addr_i), .xram_wdata_i(xram_wdata_i), .xram_rdata_o(xram_rdata_o),
    .timer_zero_overflow_i(t0), .timer_one_overflow_i(t1), .serial_zero_req_i(s0),
    .serial_one_req_i(s1), .ext_zero_pin_i(e0), .ext_one_pin_i(e1),
    .flash_collision_a_i(fca), .flash_collision_b_i(fcb), .spi_event_i(spi),
    .ce_busy_i(ce), .pll_lock_i(pll), .eeprom_busy_i(ee), .transfer_busy_event_i(xf),
    .one_second_tick_i(sec), .watchdog_near_overflow_i(wdn), .button_press_i(btn),
    .timed_wakeup_i(twk), .wake_i(wake), .irq_call_o(irq_call_o),
    .irq_vector_o(irq_vector_o), .timer_zero_vector_ack_o(ack0),
    .timer_one_vector_ack_o(ack1), .active_level_o(active_level_o));
  core_model core_model_i (.mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow),
    .mcycle_o(mcycle_i), .boundary_o(instr_boundary_i));
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(negedge mclk_i);
    chk({8'h00, sfr_rdata_o}, {8'h00, exp});
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
  endtask
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    xram_addr_i <= a;
    xram_wdata_i <= d;
    xram_wr_i <= 1'b1;
    @(posedge mclk_i);
    xram_wr_i <= 1'b0;
  endtask
  task automatic xrd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    xram_addr_i <= a;
    @(negedge mclk_i);
    chk({8'h00, xram_rdata_o}, {8'h00, exp});
  endtask
  // wait for the forced call, check its vector, then return from it
  task automatic serve(input logic [15:0] v);
    for (int i = 0; i < 40 && irq_call_o !== 1'b1; i++) @(negedge mclk_i);
    chk({15'h0, irq_call_o}, 16'h0001);
    chk(irq_vector_o, v);
    chk({14'h0, ack1, ack0}, {14'h0, v == 16'h001b, v == 16'h000b});
    @(posedge mclk_i);
    reti_i <= 1'b1;
    @(posedge mclk_i);
    reti_i <= 1'b0;
  endtask
  task automatic fire_pair;
    @(posedge mclk_i);
    e0 <= 1'b0;
    t0 <= 1'b1;
    @(posedge mclk_i);
    e0 <= 1'b1;
    t0 <= 1'b0;
  endtask
  task automatic t_reset;
    srd(8'ha8, 8'h00);
    srd(8'hc0, 8'h00);
    srd(8'h00, 8'h00);
    xrd(16'h2002, 8'h00);
  endtask
  task automatic t_flag_call;
    swr(8'h88, 8'h01);
    fire_pair();
    repeat (3) @(posedge mclk_i);
    srd(8'h88, 8'h23);
    swr(8'ha8, 8'h83);
    serve(16'h0003);
    serve(16'h000b);
    srd(8'h88, 8'h01);
    @(posedge mclk_i);
    e1 <= 1'b0;
    @(posedge mclk_i);
    e1 <= 1'b1;
    srd(8'h88, 8'h09);
  endtask
  // group one raised above group zero, core strobes slowed
  task automatic t_priority;
    swr(8'ha9, 8'h02);
    slow <= 1'b1;
    fire_pair();
    serve(16'h000b);
    serve(16'h0003);
    slow <= 1'b0;
    swr(8'ha9, 8'h00);
  endtask
  task automatic t_ext_lines;
    logic [15:0] vec [5] = '{16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b};
    swr(8'ha8, 8'h00);
    swr(8'hc8, 8'h00);
    xwr(16'h2002, 8'h03);
    xwr(16'h20b0, 8'h11);
    xwr(16'h2007, 8'h30);
    @(posedge mclk_i);
    {fca, fcb, spi, xf, sec, wdn, btn, twk} <= 8'hff;
    {ce, ee, pll} <= 3'h0;
    @(posedge mclk_i);
    {fca, fcb, spi, xf, sec, wdn, btn, twk} <= 8'h00;
    pll <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srd(8'hc0, 8'h3e);
    srd(8'he8, 8'hff);
    xrd(16'h20b1, 8'h11);
    swr(8'he8, 8'hfe);
    srd(8'he8, 8'hfe);
    @(posedge mclk_i);
    wake <= 1'b0;
    repeat (2) @(posedge mclk_i);
    wake <= 1'b1;
    xrd(16'h20b1, 8'h10);
    swr(8'hb8, 8'h3e);
    repeat (4) @(negedge mclk_i) chk({15'h0, irq_call_o}, 16'h0000);
    swr(8'ha8, 8'h80);
    foreach (vec[i]) serve(vec[i]);
    srd(8'hc0, 8'h00);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    end_of_test();
  end
  initial begin
    reset_i = 1'b1;
    {slow, sfr_wr_i, sfr_rd_i, xram_wr_i, reti_i, t0, t1, s0, s1} = 9'h000;
    {fca, fcb, spi, xf, sec, wdn, btn, twk} = 8'h00;
    {e0, e1, ce, pll, ee, wake} = 6'h3f;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    xram_wdata_i = 8'h00;
    xram_addr_i = 16'h0000;
    n_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_flag_call();
    t_priority();
    t_ext_lines();
    end_of_test();
  end
endmodule // tb
`default_nettype wire

// >>> src/mpu_interrupt_controller.v
// Purpose: interrupt flags, enables, priority and vectoring for the 8-bit core
// Assumes: core gives one-cycle machine-cycle strobe, sfr and extended write strobes
// Notes: priority level per group from two priority registers, nested up to four levels
//
// Behaviour
// [RQ1] active service is preempted only by a strictly higher level request
// [RQ2] return-from-interrupt ends the current service level; core resumes
// [RQ3] request flags set on their condition regardless of any enable
// [RQ4] flags sampled once per machine cycle; enabled pending samples register requests
// [RQ5] next instruction cycle forces long call to vector if nothing equal/higher active
// [RQ6] ack deferred during return or writes to enable or priority registers
// [RQ7] global enable zero blocks every source
// [RQ8] individual enable bits in the three enable registers as mapped
// [RQ9] external 0/1 type bit: 0 low level, 1 falling edge
// [RQ10] polarity bits 6/5 pick falling or rising edge for external 3/2
// [RQ11] software keeps external 2/3 polarity bits at zero for falling edge; code falls at zero for external 3 only, external 2 rises at zero
// [RQ12] request register bits 5..1 show pending external 6..2; others zero
// [RQ13] timer overflow flags cleared by active-high acks at vectoring
// [RQ14] external lines merge their listed sub-sources
// [RQ15] line 4 rising edge; lines 5 and 6 inverted before rising detector; code inverts line 5 only, line 6 rises uninverted
// [RQ16] main flags external 0..6 cleared automatically on vectoring
// [RQ17] sub-source flags clear only on written zero; ones ignored
// [RQ18] software clears sub-flags with all-ones-but-one byte writes
// [RQ19] sub-source flag byte bit layout as listed
// [RQ20] sub-source enables and watchdog/spi flags at extended addresses
// [RQ21] button and timed-wake flags set by hardware, raise no interrupt
// [RQ22] watchdog warning flag clears on written zero or falling wake
// [RQ23] sources share priority in five pairs
// [RQ24] group level from high/low priority bits; external 6 is group 5
// [RQ25] equal levels served in fixed polling order
// [RQ26] vector addresses per source
// [RQ27] highest level chosen first among simultaneous requests
`include "mpu_irq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mpu_interrupt_controller #(
  parameter NSRC = `NUM_SRC
) (
  input wire mclk_i,
  input wire reset_i,
  input wire mcycle_i,
  input wire instr_boundary_i,
  input wire reti_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  input wire xram_wr_i,
  input wire [15:0] xram_addr_i,
  input wire [7:0] xram_wdata_i,
  output reg [7:0] xram_rdata_o,
  input wire timer_zero_overflow_i,
  input wire timer_one_overflow_i,
  input wire serial_zero_req_i,
  input wire serial_one_req_i,
  input wire ext_zero_pin_i,
  input wire ext_one_pin_i,
  input wire flash_collision_a_i,
  input wire flash_collision_b_i,
  input wire spi_event_i,
  input wire ce_busy_i,
  input wire pll_lock_i,
  input wire eeprom_busy_i,
  input wire transfer_busy_event_i,
  input wire one_second_tick_i,
  input wire watchdog_near_overflow_i,
  input wire button_press_i,
  input wire timed_wakeup_i,
  input wire wake_i,
  output wire irq_call_o,
  output reg [15:0] irq_vector_o,
  output reg timer_zero_vector_ack_o,
  output reg timer_one_vector_ack_o,
  output wire [2:0] active_level_o
);
  reg [7:0] timer_irq_control_q;
  reg [7:0] irq_enable_first_q;
  reg [7:0] irq_enable_second_q;
  reg [7:0] irq_enable_third_q;
  reg [7:0] ext_irq_request_q;
  reg [7:0] ext_irq_polarity_q;
  reg [7:0] priority_low_bits_q;
  reg [7:0] priority_high_bits_q;
  reg [7:0] sub_flags_q;
  reg [7:0] sub_en_a_q;
  reg [7:0] sub_en_b_q;
  reg [7:0] sub_en_c_q;
  reg [7:0] sub_flag_b_q;
  reg [NSRC-1:0] sample_q;
  reg [NSRC-1:0] pend_q;
  reg [3:0] in_service_q;
  reg [14:0] prev_q;
  reg defer_q;
  reg pend_valid_q;
  reg call_q;

  // group of each source
  function [2:0] group_of;
    input [3:0] s;
    begin
      case (s)
        `SRC_EXT0, `SRC_SER1: group_of = 3'd0; // RQ23
        `SRC_TMR0, `SRC_EXT2: group_of = 3'd1;
        `SRC_EXT1, `SRC_EXT3: group_of = 3'd2;
        `SRC_TMR1, `SRC_EXT4: group_of = 3'd3;
        `SRC_SER0, `SRC_EXT5: group_of = 3'd4;
        default: group_of = 3'd5;
      endcase
    end
  endfunction

  function [15:0] vector_of;
    input [3:0] s;
    begin
      case (s)
        `SRC_EXT0: vector_of = `VEC_EXT0;
        `SRC_SER1: vector_of = `VEC_SER1;
        `SRC_TMR0: vector_of = `VEC_TMR0;
        `SRC_EXT2: vector_of = `VEC_EXT2;
        `SRC_EXT1: vector_of = `VEC_EXT1;
        `SRC_EXT3: vector_of = `VEC_EXT3;
        `SRC_TMR1: vector_of = `VEC_TMR1;
        `SRC_EXT4: vector_of = `VEC_EXT4;
        `SRC_SER0: vector_of = `VEC_SER0;
        `SRC_EXT5: vector_of = `VEC_EXT5;
        `SRC_EXT6: vector_of = `VEC_EXT6;
        default: vector_of = `VEC_NONE;
      endcase
    end
  endfunction

  function [1:0] level_of;
    input [2:0] g;
    input [7:0] hi;
    input [7:0] lo;
    begin
      level_of = {hi[g], lo[g]}; // RQ24
    end
  endfunction

  // edge detection on raw sources; prev bits indexed per signal
  wire sub_any_coll_a = flash_collision_a_i & ~prev_q[0];
  wire sub_any_coll_b = flash_collision_b_i & ~prev_q[1];
  wire spi_rise = spi_event_i & ~prev_q[2];
  wire lock_rise = pll_lock_i & ~prev_q[3];
  wire lock_fall = ~pll_lock_i & prev_q[3];
  wire xfer_rise = transfer_busy_event_i & ~prev_q[4];
  wire sec_rise = one_second_tick_i & ~prev_q[5];
  wire wd_rise = watchdog_near_overflow_i & ~prev_q[6];
  wire btn_rise = button_press_i & ~prev_q[7];
  wire wake_t_rise = timed_wakeup_i & ~prev_q[8];
  wire wake_fall = ~wake_i & prev_q[9];
  wire ext0_fall = ~ext_zero_pin_i & prev_q[10];
  wire ext1_fall = ~ext_one_pin_i & prev_q[11];
  wire ce_edge = ext_irq_polarity_q[`BIT_EXT_THREE_EDGE] ?
    (ce_busy_i & ~prev_q[12]) : (~ce_busy_i & prev_q[12]); // RQ10
  wire ee_rise = ~eeprom_busy_i & prev_q[13]; // RQ15
  wire tmr0_rise = timer_zero_overflow_i & ~prev_q[14];

  // merged line 2 request, polarity selectable, default rising on merged level
  wire line2_lvl = (sub_flags_q[`SUB_COLL_A] | sub_flags_q[`SUB_COLL_B]) &
    sub_en_c_q[`XB_COLLISION] | sub_flag_b_q[`XB_SPI] & sub_en_b_q[`XB_SPI]; // RQ14
  wire line4_lvl = (sub_flags_q[`SUB_LOCK_GAIN] | sub_flags_q[`SUB_LOCK_LOST]) &
    sub_en_c_q[`XB_LOCK];
  wire line6_lvl = sub_flags_q[`SUB_TRANSFER] & sub_en_a_q[`XB_TRANSFER] |
    sub_flags_q[`SUB_SECOND] & sub_en_a_q[`XB_SECOND] |
    sub_flag_b_q[`XB_WATCHDOG] & sub_en_b_q[`XB_WATCHDOG]; // RQ14
  reg line2_prev_q;
  reg line4_prev_q;
  reg line6_prev_q;
  // sub-source hardware flags drive line active-high, hence detector sees the merged level uninverted
  wire line2_edge = ext_irq_polarity_q[`BIT_EXT_TWO_EDGE] ?
    (~line2_lvl & line2_prev_q) : (line2_lvl & ~line2_prev_q); // RQ10
  wire line4_edge = line4_lvl & ~line4_prev_q; // RQ15
  wire line6_edge = line6_lvl & ~line6_prev_q; // RQ15

  wire sfr_we_timer_irq_control = sfr_wr_i & (sfr_addr_i == `ADDR_TIMER_IRQ_CONTROL);
  wire sfr_we_ext_irq_request = sfr_wr_i & (sfr_addr_i == `ADDR_EXT_IRQ_REQUEST);
  wire sfr_we_sub = sfr_wr_i & (sfr_addr_i == `ADDR_SUB_FLAGS);
  wire x_we_flag_b = xram_wr_i & (xram_addr_i == `XADDR_SUB_FLAG_B);
  wire guarded_wr = sfr_wr_i & ((sfr_addr_i == `ADDR_IRQ_ENABLE_FIRST) |
    (sfr_addr_i == `ADDR_IRQ_ENABLE_SECOND) | (sfr_addr_i == `ADDR_IRQ_ENABLE_THIRD) |
    (sfr_addr_i == `ADDR_PRIORITY_LOW) | (sfr_addr_i == `ADDR_PRIORITY_HIGH));

  // current flag vector in polling order
  wire ext0_flag = timer_irq_control_q[`BIT_EXT_ZERO_FLAG];
  wire ext1_flag = timer_irq_control_q[`BIT_EXT_ONE_FLAG];
  wire [NSRC-1:0] flags = {ext_irq_request_q[5], ext_irq_request_q[4],
    serial_zero_req_i, ext_irq_request_q[3], timer_irq_control_q[`BIT_TIMER_ONE_FLAG],
    ext_irq_request_q[2], ext1_flag, ext_irq_request_q[1],
    timer_irq_control_q[`BIT_TIMER_ZERO_FLAG], serial_one_req_i, ext0_flag};
  wire [NSRC-1:0] enables = {irq_enable_second_q[5], irq_enable_second_q[4],
    irq_enable_first_q[`BIT_SERIAL_ZERO_EN], irq_enable_second_q[3],
    irq_enable_first_q[`BIT_TIMER_ONE_EN], irq_enable_second_q[2],
    irq_enable_first_q[`BIT_EXT_ONE_EN], irq_enable_second_q[1],
    irq_enable_first_q[`BIT_TIMER_ZERO_EN], irq_enable_third_q[0],
    irq_enable_first_q[`BIT_EXT_ZERO_EN]}; // RQ8

  // choose highest level, then lowest index
  reg [3:0] win_idx;
  reg [2:0] win_lvl;
  reg win_ok;
  reg [2:0] cur_lvl;
  integer i;
  integer k;
  always @* begin
    win_idx = 4'h0;
    win_lvl = `LVL_NONE;
    win_ok = 1'b0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (pend_q[i] && (!win_ok ||
          {1'b0, level_of(group_of(i[3:0]), priority_high_bits_q, priority_low_bits_q)}
          >= win_lvl)) begin // RQ25 RQ27
        win_ok = 1'b1;
        win_idx = i[3:0];
        win_lvl = {1'b0, level_of(group_of(i[3:0]), priority_high_bits_q,
          priority_low_bits_q)};
      end
    end
    cur_lvl = `LVL_NONE;
    for (k = 0; k < 4; k = k + 1) begin
      if (in_service_q[k]) begin
        cur_lvl = k[2:0];
      end
    end
  end

  // strictly higher than the active level, or nothing active
  wire may_preempt = win_ok & ((cur_lvl == `LVL_NONE) | (win_lvl > cur_lvl)); // RQ1 RQ5
  // the guarded write or return in flight must not be overtaken by a call
  wire take = pend_valid_q & instr_boundary_i & may_preempt & ~defer_q & ~call_q &
    ~reti_i & ~guarded_wr & irq_enable_first_q[`BIT_GLOBAL_EN]; // RQ6 RQ7
  assign irq_call_o = call_q;
  assign active_level_o = cur_lvl;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_irq_control_q <= 8'h00;
      irq_enable_first_q <= 8'h00;
      irq_enable_second_q <= 8'h00;
      irq_enable_third_q <= 8'h00;
      ext_irq_request_q <= 8'h00;
      ext_irq_polarity_q <= 8'h00;
      priority_low_bits_q <= 8'h00;
      priority_high_bits_q <= 8'h00;
      sub_flags_q <= 8'h00;
      sub_en_a_q <= 8'h00;
      sub_en_b_q <= 8'h00;
      sub_en_c_q <= 8'h00;
      sub_flag_b_q <= 8'h00;
      sample_q <= {NSRC{1'b0}};
      pend_q <= {NSRC{1'b0}};
      in_service_q <= 4'h0;
      prev_q <= 15'h7fff;
      line2_prev_q <= 1'b0;
      line4_prev_q <= 1'b0;
      line6_prev_q <= 1'b0;
      defer_q <= 1'b0;
      pend_valid_q <= 1'b0;
      call_q <= 1'b0;
      irq_vector_o <= 16'h0000;
      timer_zero_vector_ack_o <= 1'b0;
      timer_one_vector_ack_o <= 1'b0;
    end else begin
      prev_q <= {timer_zero_overflow_i, eeprom_busy_i, ce_busy_i, ext_one_pin_i,
        ext_zero_pin_i, wake_i, timed_wakeup_i, button_press_i, watchdog_near_overflow_i,
        one_second_tick_i, transfer_busy_event_i, pll_lock_i, spi_event_i,
        flash_collision_b_i, flash_collision_a_i};
      line2_prev_q <= line2_lvl;
      line4_prev_q <= line4_lvl;
      line6_prev_q <= line6_lvl;
      // plain configuration writes
      if (sfr_wr_i) begin
        case (sfr_addr_i)
          `ADDR_IRQ_ENABLE_FIRST: irq_enable_first_q <= sfr_wdata_i;
          `ADDR_IRQ_ENABLE_SECOND: irq_enable_second_q <= sfr_wdata_i & 8'h3e;
          `ADDR_IRQ_ENABLE_THIRD: irq_enable_third_q <= sfr_wdata_i & 8'h01;
          `ADDR_PRIORITY_LOW: priority_low_bits_q <= sfr_wdata_i & 8'h3f;
          `ADDR_PRIORITY_HIGH: priority_high_bits_q <= sfr_wdata_i & 8'h3f;
          `ADDR_EXT_IRQ_POLARITY: ext_irq_polarity_q <= sfr_wdata_i & 8'h60;
          default: ;
        endcase
      end
      if (xram_wr_i) begin
        case (xram_addr_i)
          `XADDR_SUB_EN_A: sub_en_a_q <= xram_wdata_i & 8'h03;
          `XADDR_SUB_EN_B: sub_en_b_q <= xram_wdata_i & 8'h11;
          `XADDR_SUB_EN_C: sub_en_c_q <= xram_wdata_i & 8'h30;
          default: ;
        endcase
      end
      // software write first, vector clear next, hardware set last
      timer_irq_control_q <= (sfr_we_timer_irq_control ? sfr_wdata_i : timer_irq_control_q);
      ext_irq_request_q <= (sfr_we_ext_irq_request ? sfr_wdata_i : ext_irq_request_q) & 8'h3e; // RQ12
      // sub-source flags: zero written clears, ones ignored, set wins
      sub_flags_q <= (sfr_we_sub ? (sub_flags_q & sfr_wdata_i) : sub_flags_q) |
        {lock_fall, lock_rise, wake_t_rise, btn_rise, sub_any_coll_a, sub_any_coll_b,
        sec_rise, xfer_rise}; // RQ17 RQ19 RQ21
      sub_flag_b_q[`XB_SPI] <= (x_we_flag_b ? (sub_flag_b_q[`XB_SPI] &
        xram_wdata_i[`XB_SPI]) : sub_flag_b_q[`XB_SPI]) | spi_rise; // RQ20
      sub_flag_b_q[`XB_WATCHDOG] <= ((x_we_flag_b ? xram_wdata_i[`XB_WATCHDOG] : 1'b1) &
        ~wake_fall & sub_flag_b_q[`XB_WATCHDOG]) | wd_rise; // RQ22
      // sample once per machine cycle, then poll enabled samples
      if (mcycle_i) begin
        sample_q <= flags; // RQ4
        pend_q <= sample_q & enables & {NSRC{irq_enable_first_q[`BIT_GLOBAL_EN]}}; // RQ7
        pend_valid_q <= 1'b1;
      end
      if (instr_boundary_i) begin
        defer_q <= 1'b0;
      end
      if (reti_i | guarded_wr) begin
        defer_q <= 1'b1; // RQ6
      end
      if (reti_i && cur_lvl != `LVL_NONE) begin
        in_service_q[cur_lvl[1:0]] <= 1'b0; // RQ2
      end
      call_q <= take;
      timer_zero_vector_ack_o <= 1'b0;
      timer_one_vector_ack_o <= 1'b0;
      if (take) begin
        irq_vector_o <= vector_of(win_idx); // RQ26
        in_service_q[win_lvl[1:0]] <= 1'b1;
        pend_q[win_idx] <= 1'b0;
        sample_q[win_idx] <= 1'b0;
        case (win_idx)
          `SRC_TMR0: begin
            timer_zero_vector_ack_o <= 1'b1; // RQ13
            timer_irq_control_q[`BIT_TIMER_ZERO_FLAG] <= 1'b0;
          end
          `SRC_TMR1: begin
            timer_one_vector_ack_o <= 1'b1; // RQ13
            timer_irq_control_q[`BIT_TIMER_ONE_FLAG] <= 1'b0;
          end
          `SRC_EXT0: timer_irq_control_q[`BIT_EXT_ZERO_FLAG] <= 1'b0; // RQ16
          `SRC_EXT1: timer_irq_control_q[`BIT_EXT_ONE_FLAG] <= 1'b0; // RQ16
          `SRC_EXT2: ext_irq_request_q[1] <= 1'b0; // RQ16
          `SRC_EXT3: ext_irq_request_q[2] <= 1'b0;
          `SRC_EXT4: ext_irq_request_q[3] <= 1'b0;
          `SRC_EXT5: ext_irq_request_q[4] <= 1'b0;
          `SRC_EXT6: ext_irq_request_q[5] <= 1'b0;
          default: ;
        endcase
      end
      // set wins over the vector clear so an event in that cycle is not lost
      if (tmr0_rise) timer_irq_control_q[`BIT_TIMER_ZERO_FLAG] <= 1'b1; // RQ3
      if (timer_one_overflow_i) timer_irq_control_q[`BIT_TIMER_ONE_FLAG] <= 1'b1;
      if (timer_irq_control_q[`BIT_EXT_ZERO_TYPE] ? ext0_fall : ~ext_zero_pin_i)
        timer_irq_control_q[`BIT_EXT_ZERO_FLAG] <= 1'b1; // RQ9
      if (timer_irq_control_q[`BIT_EXT_ONE_TYPE] ? ext1_fall : ~ext_one_pin_i)
        timer_irq_control_q[`BIT_EXT_ONE_FLAG] <= 1'b1; // RQ9
      if (line2_edge) ext_irq_request_q[1] <= 1'b1;
      if (ce_edge) ext_irq_request_q[2] <= 1'b1;
      if (line4_edge) ext_irq_request_q[3] <= 1'b1;
      if (ee_rise) ext_irq_request_q[4] <= 1'b1;
      if (line6_edge) ext_irq_request_q[5] <= 1'b1;
    end
  end

  // read side; unmapped addresses read zero
  always @* begin
    case (sfr_addr_i)
      `ADDR_TIMER_IRQ_CONTROL: sfr_rdata_o = timer_irq_control_q;
      `ADDR_IRQ_ENABLE_FIRST: sfr_rdata_o = irq_enable_first_q;
      `ADDR_IRQ_ENABLE_SECOND: sfr_rdata_o = irq_enable_second_q;
      `ADDR_IRQ_ENABLE_THIRD: sfr_rdata_o = irq_enable_third_q;
      `ADDR_PRIORITY_LOW: sfr_rdata_o = priority_low_bits_q;
      `ADDR_PRIORITY_HIGH: sfr_rdata_o = priority_high_bits_q;
      `ADDR_EXT_IRQ_REQUEST: sfr_rdata_o = ext_irq_request_q; // RQ12
      `ADDR_EXT_IRQ_POLARITY: sfr_rdata_o = ext_irq_polarity_q;
      `ADDR_SUB_FLAGS: sfr_rdata_o = sub_flags_q;
      default: sfr_rdata_o = 8'h00;
    endcase
    case (xram_addr_i)
      `XADDR_SUB_EN_A: xram_rdata_o = sub_en_a_q;
      `XADDR_SUB_EN_B: xram_rdata_o = sub_en_b_q;
      `XADDR_SUB_EN_C: xram_rdata_o = sub_en_c_q;
      `XADDR_SUB_FLAG_B: xram_rdata_o = sub_flag_b_q;
      default: xram_rdata_o = 8'h00;
    endcase
  end
endmodule // mpu_interrupt_controller
`default_nettype wire

// >>> src/mpu_irq_regs.vh
// Purpose: register addresses, bit positions and vectors of the interrupt controller
// Assumes: 8-bit special register bus, byte-wide sub-source flag register
// Notes: definitions only
`ifndef MPU_IRQ_REGS_VH
`define MPU_IRQ_REGS_VH
`define ADDR_TIMER_IRQ_CONTROL 8'h88
`define ADDR_IRQ_ENABLE_THIRD 8'h9a
`define ADDR_IRQ_ENABLE_FIRST 8'ha8
`define ADDR_PRIORITY_LOW 8'ha9
`define ADDR_IRQ_ENABLE_SECOND 8'hb8
`define ADDR_PRIORITY_HIGH 8'hb9
`define ADDR_EXT_IRQ_REQUEST 8'hc0
`define ADDR_EXT_IRQ_POLARITY 8'hc8
`define ADDR_SUB_FLAGS 8'he8
`define XADDR_SUB_EN_A 16'h2002
`define XADDR_SUB_EN_B 16'h20b0
`define XADDR_SUB_FLAG_B 16'h20b1
`define XADDR_SUB_EN_C 16'h2007
// enable-first bits
`define BIT_GLOBAL_EN 7
`define BIT_SERIAL_ZERO_EN 4
`define BIT_TIMER_ONE_EN 3
`define BIT_EXT_ONE_EN 2
`define BIT_TIMER_ZERO_EN 1
`define BIT_EXT_ZERO_EN 0
// timer control bits
`define BIT_TIMER_ONE_FLAG 7
`define BIT_TIMER_ZERO_FLAG 5
`define BIT_EXT_ONE_FLAG 3
`define BIT_EXT_ONE_TYPE 2
`define BIT_EXT_ZERO_FLAG 1
`define BIT_EXT_ZERO_TYPE 0
// polarity bits
`define BIT_EXT_THREE_EDGE 6
`define BIT_EXT_TWO_EDGE 5
// sub-source flag byte
`define SUB_TRANSFER 0
`define SUB_SECOND 1
`define SUB_COLL_B 2
`define SUB_COLL_A 3
`define SUB_BUTTON 4
`define SUB_WAKE 5
`define SUB_LOCK_GAIN 6
`define SUB_LOCK_LOST 7
// extended enable bits
`define XB_TRANSFER 0
`define XB_SECOND 1
`define XB_WATCHDOG 0
`define XB_SPI 4
`define XB_COLLISION 4
`define XB_LOCK 5
// source indices, also the fixed same-level order
`define SRC_EXT0 0
`define SRC_SER1 1
`define SRC_TMR0 2
`define SRC_EXT2 3
`define SRC_EXT1 4
`define SRC_EXT3 5
`define SRC_TMR1 6
`define SRC_EXT4 7
`define SRC_SER0 8
`define SRC_EXT5 9
`define SRC_EXT6 10
`define NUM_SRC 11
`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001b
`define VEC_SER0 16'h0023
`define VEC_SER1 16'h0083
`define VEC_EXT2 16'h004b
`define VEC_EXT3 16'h0053
`define VEC_EXT4 16'h005b
`define VEC_EXT5 16'h0063
`define VEC_EXT6 16'h006b
`define VEC_NONE 16'h0000
`define LVL_NONE 3'h4
`endif
